// ---- core/zwsg_pkg.sv ----
// Package for the zero wait-state static RAM glue
package zwsg_pkg;
   // Device selects on the shared data bus; the example RAM has its own select, ram_cs_n
   localparam int unsigned NUM_DEV = 4;
   // Example RAM window, external word addresses
   localparam logic [23:0] RAM_BASE = 24'h000000;
   localparam logic [23:0] RAM_LAST = 24'h003FFF;
   // Address bit that splits the lower half, where the main bus selects the RAM, from the upper half
   localparam int unsigned TOP_BIT = 23;
   // Bank field position for large memories
   localparam int unsigned BANK_LSB = 16;
   localparam int unsigned BANK_W = 2;
   // Reset value of the registered bus status
   localparam logic [1:0] STAT_RST = 2'h0;
   // One bus cycle as seen by the glue
   typedef struct packed {
      logic strobe_n;
      logic rw;
      logic [23:0] addr;
   } zwsg_bus_s;
   // Bus phase of the glue monitor
   typedef enum logic [1:0] {ZWSG_IDLE, ZWSG_READ, ZWSG_WRITE} zwsg_phase_e;
endpackage

// ---- core/zwsg_glue.sv ----
// Zero wait-state chip-select glue between processor buses and static RAMs
`timescale 1ns/1ps
module zwsg_glue (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic single_bank_mode,
   input wire logic [zwsg_pkg::NUM_DEV-1:0] dev_decode,
   input wire logic main_bus_strobe_n,
   input wire logic main_rw,
   input wire logic [23:0] main_addr,
   input wire logic secondary_memory_strobe_n,
   input wire logic secondary_io_strobe_n,
   input wire logic secondary_rw,
   input wire logic [23:0] secondary_addr,
   output logic [zwsg_pkg::NUM_DEV-1:0] main_cs_n,
   output logic [(1<<zwsg_pkg::BANK_W)-1:0] main_bank_cs_n,
   output logic ram_cs_n,
   output logic ram_we_n,
   output logic ram_oe_n,
   output logic sec_mem_cs_n,
   output logic sec_mem_we_n,
   output logic sec_io_cs_n,
   output logic sec_io_we_n,
   output logic [1:0] bus_status_r,
   output logic strobe_clash_r
);
   // Example RAM window check, used on the secondary bus only; the main bus uses the top bit
   function automatic logic in_ram_window(input logic [23:0] a);
      in_ram_window = (a >= zwsg_pkg::RAM_BASE) && (a <= zwsg_pkg::RAM_LAST);
   endfunction

   zwsg_pkg::zwsg_bus_s main_bus;
   zwsg_pkg::zwsg_phase_e phase_r;
   zwsg_pkg::zwsg_phase_e phase_nxt;
   logic [zwsg_pkg::BANK_W-1:0] bank_sel;
   logic io_active;

   assign main_bus = '{strobe_n: main_bus_strobe_n, rw: main_rw, addr: main_addr};
   assign bank_sel = main_bus.addr[zwsg_pkg::BANK_LSB +: zwsg_pkg::BANK_W];

   // Example RAM: strobe AND inverted top bit, one gate, no flops
   assign ram_cs_n = main_bus.strobe_n | main_bus.addr[zwsg_pkg::TOP_BIT];
   // Write enable straight from read/write; strobe comes later, so CS controls
   assign ram_we_n = main_bus.rw;
   // Tied low; saves a gate delay, the RAM keeps its outputs off unless read
   assign ram_oe_n = 1'b0;

   // Select is strobe AND inverted top bit, nothing else
   ram_select_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!ram_cs_n) == (!main_bus_strobe_n && !main_addr[zwsg_pkg::TOP_BIT]))
      else $error("ram select wrong");

   // Upper half of the space never reaches the example RAM
   ram_upper_off_a: assert property (@(posedge clk_sys) disable iff (reset)
      main_addr[zwsg_pkg::TOP_BIT] |-> ram_cs_n)
      else $error("ram selected above its window");

   // Write enable copies read/write, output enable stays low
   ram_we_a: assert property (@(posedge clk_sys) disable iff (reset)
      ram_we_n == main_rw && !ram_oe_n)
      else $error("ram we or oe wrong");

   // A selected write always carries write enable low with it
   ram_write_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!ram_cs_n && !main_rw) |-> !ram_we_n)
      else $error("ram write without write enable");

   // Per-device chip selects; single bank mode bypasses the decode
   always_comb begin
      for (int i = 0; i < zwsg_pkg::NUM_DEV; i++) begin
         if (single_bank_mode) begin
            main_cs_n[i] = main_bus.strobe_n;
         end else begin
            main_cs_n[i] = main_bus.strobe_n | ~dev_decode[i];
         end
      end
   end

   // Single bank: every select is the strobe itself
   single_bank_a: assert property (@(posedge clk_sys) disable iff (reset)
      single_bank_mode |-> main_cs_n == {zwsg_pkg::NUM_DEV{main_bus_strobe_n}})
      else $error("single bank select wrong");

   // Shared bus: decode AND strobe per device
   shared_cs_a: assert property (@(posedge clk_sys) disable iff (reset)
      !single_bank_mode |-> main_cs_n == ~(dev_decode & {zwsg_pkg::NUM_DEV{!main_bus_strobe_n}}))
      else $error("shared select wrong");

   // Shared bus: a device that is not decoded stays deselected
   decode_off_a: assert property (@(posedge clk_sys) disable iff (reset)
      !single_bank_mode |-> &(main_cs_n | dev_decode))
      else $error("undecoded device selected");

   // No strobe, no select anywhere on the main bus
   no_strobe_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      main_bus_strobe_n |-> ram_cs_n && (&main_cs_n))
      else $error("select without strobe");

   // Bank selects for large memory; few address bits keep it one gate deep
   always_comb begin
      for (int b = 0; b < (1 << zwsg_pkg::BANK_W); b++) begin
         main_bank_cs_n[b] = main_bus.strobe_n
            | (bank_sel != zwsg_pkg::BANK_W'(b));
      end
   end

   // Exactly one bank per strobed access
   bank_onehot_a: assert property (@(posedge clk_sys) disable iff (reset)
      !main_bus_strobe_n |-> $onehot(~main_bank_cs_n))
      else $error("bank select not one-hot");

   // Banks all off between accesses
   bank_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      main_bus_strobe_n |-> &main_bank_cs_n)
      else $error("bank select without strobe");

   // The bank picked is the one the address field names
   bank_index_a: assert property (@(posedge clk_sys) disable iff (reset)
      !main_bus_strobe_n |-> !main_bank_cs_n[main_addr[zwsg_pkg::BANK_LSB +: zwsg_pkg::BANK_W]])
      else $error("wrong bank selected");

   // Secondary memory side decodes the RAM window, not the top bit, and an I/O strobe blocks it; no bank selects
   assign io_active = ~secondary_io_strobe_n;
   assign sec_mem_cs_n = secondary_memory_strobe_n | io_active
      | ~in_ram_window(secondary_addr);
   assign sec_mem_we_n = secondary_rw;
   // I/O interface locked out while a memory strobe is live
   assign sec_io_cs_n = secondary_io_strobe_n | ~secondary_memory_strobe_n;
   assign sec_io_we_n = secondary_rw;

   // The two secondary interfaces never select together
   secondary_excl_a: assert property (@(posedge clk_sys) disable iff (reset)
      !(!sec_mem_cs_n && !sec_io_cs_n))
      else $error("secondary selects both active");

   // A lone memory strobe inside the window selects the memory
   secondary_mem_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!secondary_memory_strobe_n && secondary_io_strobe_n
      && secondary_addr <= zwsg_pkg::RAM_LAST) |-> !sec_mem_cs_n)
      else $error("secondary memory select missing");

   // A live I/O strobe keeps the memory side off
   sec_mem_block_a: assert property (@(posedge clk_sys) disable iff (reset)
      !secondary_io_strobe_n |-> sec_mem_cs_n)
      else $error("memory select during io strobe");

   // A live memory strobe keeps the I/O side off
   sec_io_block_a: assert property (@(posedge clk_sys) disable iff (reset)
      !secondary_memory_strobe_n |-> sec_io_cs_n)
      else $error("io select during memory strobe");

   // A lone I/O strobe selects the I/O side
   sec_io_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!secondary_io_strobe_n && secondary_memory_strobe_n) |-> !sec_io_cs_n)
      else $error("io select missing");

   // Both secondary write enables follow read/write
   sec_we_a: assert property (@(posedge clk_sys) disable iff (reset)
      sec_mem_we_n == secondary_rw && sec_io_we_n == secondary_rw)
      else $error("secondary write enable wrong");

   // Bus phase for status only; selects never wait on it
   always_comb begin
      phase_nxt = zwsg_pkg::ZWSG_IDLE;
      case ({ram_cs_n, main_bus.rw})
         2'h0: phase_nxt = zwsg_pkg::ZWSG_WRITE;
         2'h1: phase_nxt = zwsg_pkg::ZWSG_READ;
         default: phase_nxt = zwsg_pkg::ZWSG_IDLE;
      endcase
   end

   // Access phase, sampled once per bus clock
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         phase_r <= zwsg_pkg::ZWSG_IDLE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // Registered status: bit0 read seen, bit1 write seen
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bus_status_r <= zwsg_pkg::STAT_RST;
      end else begin
         bus_status_r <= {phase_r == zwsg_pkg::ZWSG_WRITE, phase_r == zwsg_pkg::ZWSG_READ};
      end
   end

   // A RAM write shows in the status two edges later
   status_write_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!ram_cs_n && !main_rw) |-> ##2 bus_status_r == 2'h2)
      else $error("write status late");

   // A RAM read shows in the status two edges later
   status_read_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!ram_cs_n && main_rw) |-> ##2 bus_status_r == 2'h1)
      else $error("read status late");

   // No RAM access, no status two edges later
   status_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      ram_cs_n |-> ##2 bus_status_r == 2'h0)
      else $error("status without access");

   // Both secondary strobes low is a partner fault; flagged, I/O stays off
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         strobe_clash_r <= 1'b0;
      end else begin
         strobe_clash_r <= ~secondary_memory_strobe_n & ~secondary_io_strobe_n;
      end
   end

   // Clash flag raised one edge after both strobes were low
   clash_set_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!secondary_memory_strobe_n && !secondary_io_strobe_n) |=> strobe_clash_r)
      else $error("strobe clash not flagged");

   // Clash flag drops once either strobe is high
   clash_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
      (secondary_memory_strobe_n || secondary_io_strobe_n) |=> !strobe_clash_r)
      else $error("strobe clash flag stuck");
endmodule

// ---- dv/zwsg_ram_model.sv ----
// Static RAM model on the far side of the glue
`timescale 1ns/1ps
module zwsg_ram_model (
   input wire logic ram_cs_n,
   input wire logic ram_we_n,
   input wire logic ram_oe_n,
   output logic dq_oe
);
   // Drive only on a selected read, so writes never fight the processor
   assign dq_oe = !ram_cs_n && ram_we_n && !ram_oe_n;
   // Address may move under a low write enable, no state is kept here
endmodule

// ---- dv/tb_zwsg_glue.sv ----
// Self-checking testbench for the zero wait-state RAM glue
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_zwsg_glue;
   logic clk_sys = 0, reset = 1, single_bank_mode = 0, m_stb_n = 1, m_rw = 1;
   logic s_mem_n = 1, s_io_n = 1, s_rw = 1, dq_oe;
   logic [3:0] dev_decode = 4'h0, main_cs_n, bank_cs_n;
   logic [23:0] m_addr = 24'h000000, s_addr = 24'h000000, a;
   logic ram_cs_n, ram_we_n, ram_oe_n, smc_n, smw_n, sic_n, siw_n, w;
   logic [1:0] bus_status_r, st_h0 = 2'h0, st_h1 = 2'h0;
   logic strobe_clash_r, clash_h = 1'b0;
   logic [17:0] q[$];
   logic [17:0] e;
   int n_errors = 0, n_checks = 0;
   zwsg_glue i_zwsg_glue (.clk_sys(clk_sys), .reset(reset),
      .single_bank_mode(single_bank_mode), .dev_decode(dev_decode),
      .main_bus_strobe_n(m_stb_n), .main_rw(m_rw), .main_addr(m_addr),
      .secondary_memory_strobe_n(s_mem_n), .secondary_io_strobe_n(s_io_n),
      .secondary_rw(s_rw), .secondary_addr(s_addr), .main_cs_n(main_cs_n),
      .main_bank_cs_n(bank_cs_n), .ram_cs_n(ram_cs_n), .ram_we_n(ram_we_n),
      .ram_oe_n(ram_oe_n), .sec_mem_cs_n(smc_n), .sec_mem_we_n(smw_n),
      .sec_io_cs_n(sic_n), .sec_io_we_n(siw_n), .bus_status_r(bus_status_r),
      .strobe_clash_r(strobe_clash_r));
   zwsg_ram_model i_zwsg_ram_model (.ram_cs_n(ram_cs_n), .ram_we_n(ram_we_n),
      .ram_oe_n(ram_oe_n), .dq_oe(dq_oe));
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One bus cycle; the expected selects are noted as it is launched
   task automatic drive(input logic sn, input logic rw, input logic [23:0] ad);
      logic [3:0] sel;
      @(posedge clk_sys);
      #1;
      m_stb_n = sn;
      m_rw = rw;
      m_addr = ad;
      s_addr = ad;
      single_bank_mode = 1'($urandom);
      dev_decode = 4'($urandom);
      {s_mem_n, s_io_n, s_rw} = 3'($urandom); // Both strobes low a quarter of the time
      sel = single_bank_mode ? 4'hF : dev_decode;
      // Status lags two cycles, clash flag one; cycles are back to back
      q.push_back({st_h1, clash_h, sn | ad[23], rw, 1'b0, ~(sel & {4{~sn}}),
         ~((4'h1 << ad[17:16]) & {4{~sn}}),
         s_mem_n | ~s_io_n | (ad > 24'h003FFF), s_io_n | ~s_mem_n, s_rw, s_rw});
      st_h1 = st_h0;
      st_h0 = {~(sn | ad[23]) & ~rw, ~(sn | ad[23]) & rw};
      clash_h = ~s_mem_n & ~s_io_n;
   endtask
   // Watcher: outputs are settled well after the driver's change
   always @(posedge clk_sys) begin
      #5;
      if (q.size() > 0) begin
         e = q.pop_front();
         `CHK("ram_cs_n", e[14], ram_cs_n)
         `CHK("ram_we_oe", e[13:12], {ram_we_n, ram_oe_n})
         `CHK("main_cs_n", e[11:8], main_cs_n)
         `CHK("bank_cs_n", e[7:4], bank_cs_n)
         `CHK("sec_mem_cs_n", e[3], smc_n)
         `CHK("sec_io_cs_n", e[2], sic_n)
         `CHK("sec_we_n", e[1:0], {smw_n, siw_n})
         `CHK("ram_drive", ~e[14] & e[13], dq_oe)
         `CHK("bus_status_r", e[17:16], bus_status_r)
         `CHK("strobe_clash_r", e[15], strobe_clash_r)
      end
   end
   // Hang guard, ends the run as a failure
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(47));
      repeat (4) @(posedge clk_sys);
      #1 reset = 0;
      for (int i = 0; i < 300; i++) begin
         a = (i % 4 == 0) ? 24'h003FFF : (i % 4 == 1) ? 24'h004000 : 24'($urandom);
         w = 1'($urandom);
         drive(1'b1, w, a); // Read/write settles before the strobe
         drive(1'b0, w, a);
      end
      repeat (2) @(posedge clk_sys);
      finish_test();
   end
endmodule
